// ===== core/lsh_top.sv
// Handler judgement and control outputs for list sweep comparison.
// Assumes sweep controller events come from logic on ref_clk.
`timescale 1ns/1ps
`include "lsh_defs.svh"
module lsh_top
  import lsh_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sequential_sweep,
  input wire logic sweep_start,
  input wire logic analog_done,
  input wire logic [`LSH_IDX_W-1:0] analog_index,
  input wire logic cmp_valid,
  input wire logic [`LSH_IDX_W-1:0] cmp_index,
  input wire logic cmp_fail,
  output logic [`LSH_NPOINTS-2:0] point_fail_n,
  output logic point10_fail_n,
  output logic any_fail_n,
  output logic index_n,
  output logic meas_end_n
);
  lsh_judge_if judge();
  lsh_state_t state;
  logic cmp_last;
  logic flags_pend;

  lsh_collect u_collect (
    .ref_clk(ref_clk),
    .rst(rst),
    .clear(sweep_start),
    .cmp_valid(cmp_valid),
    .cmp_index(cmp_index),
    .cmp_fail(cmp_fail),
    .judge(judge)
  );

  assign cmp_last = cmp_valid && cmp_index == `LSH_LAST_IDX;

  // ****************************************
  // Sweep state.
  // ****************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= lsh_idle;
    end else begin
      case (state)
        lsh_idle: begin
          if (sweep_start) begin
            state <= lsh_run;
          end
        end
        lsh_run: begin
          if (cmp_last) begin
            state <= lsh_done;
          end
        end
        lsh_done: begin
          if (sweep_start) begin
            state <= lsh_run;
          end
        end
        default: begin
          state <= lsh_idle;
        end
      endcase
    end
  end

  // ****************************************
  // Index strobe.
  // ****************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      index_n <= 1'b1;
    end else if (sweep_start) begin
      index_n <= 1'b1;
    end else if (analog_done && analog_index == `LSH_LAST_IDX && state == lsh_run) begin
      index_n <= 1'b0;
    end
  end

  // ****************************************
  // Publish judgements two cycles after a compare lands in lsh_run; in sequential mode only after the compare of the last point.
  // ****************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flags_pend <= 1'b0;
    end else begin
      flags_pend <= cmp_valid && !sweep_start && state == lsh_run &&
                    (!sequential_sweep || cmp_index == `LSH_LAST_IDX);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      point_fail_n <= `LSH_ALL_PASS_N;
      point10_fail_n <= 1'b1;
      any_fail_n <= 1'b1;
    end else if (flags_pend) begin
      point_fail_n <= ~judge.flags[`LSH_NPOINTS-2:0];
      point10_fail_n <= ~judge.flags[`LSH_NPOINTS-1];
      any_fail_n <= ~judge.any_fail;
    end
  end

  // ****************************************
  // End of measurement strobe.
  // ****************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meas_end_n <= 1'b1;
    end else if (sweep_start || (cmp_valid && state == lsh_run)) begin
      meas_end_n <= 1'b1;
    end else if (flags_pend) begin
      meas_end_n <= 1'b0;
    end
  end

  // ****************************************
  // Checks.
  // ****************************************
  a_start_clears: assert property (@(posedge ref_clk) disable iff (rst)
    sweep_start |=> index_n && meas_end_n) else $error("strobes not cleared");
  a_end_seq_last: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(meas_end_n) && sequential_sweep |-> $past(cmp_last, 2))
    else $error("seq end early");
  a_end_step: assert property (@(posedge ref_clk) disable iff (rst)
    cmp_valid && !sweep_start && !sequential_sweep && state == lsh_run ##1 !sweep_start
    && !cmp_valid |=> !meas_end_n) else $error("step end missing");
  a_end_cause: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(meas_end_n) |-> $past(cmp_valid, 2)) else $error("end without compare");
  a_index_last: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(index_n) |-> $past(analog_done) && $past(analog_index) == `LSH_LAST_IDX)
    else $error("index not last");
  a_index_step: assert property (@(posedge ref_clk) disable iff (rst)
    analog_done && analog_index == `LSH_LAST_IDX && state == lsh_run && !sweep_start
    |=> !index_n) else $error("index missing");
  a_fail_agg: assert property (@(posedge ref_clk) disable iff (rst)
    !meas_end_n |-> any_fail_n == (&point_fail_n && point10_fail_n))
    else $error("fail mismatch");
  a_judge_stable: assert property (@(posedge ref_clk) disable iff (rst)
    !meas_end_n && $past(!meas_end_n) |-> $stable(point_fail_n) && $stable(any_fail_n))
    else $error("judgement moved");
  a_point_map: assert property (@(posedge ref_clk) disable iff (rst)
    flags_pend |=> point10_fail_n == ~$past(judge.flags[`LSH_NPOINTS-1]))
    else $error("point ten map");
  c_seq_end: cover property (@(posedge ref_clk) sequential_sweep && $fell(meas_end_n));
  c_step_end: cover property (@(posedge ref_clk) !sequential_sweep && $fell(meas_end_n));
  c_fail: cover property (@(posedge ref_clk) $fell(any_fail_n));
  c_index: cover property (@(posedge ref_clk) $fell(index_n));
endmodule

// ===== core/lsh_defs.svh
// Constants for the list sweep handler output block.
// Assumes inclusion by bare name from the core folder.
`ifndef LSH_DEFS_SVH
`define LSH_DEFS_SVH
`define LSH_NPOINTS 10
`define LSH_IDX_W 4
`define LSH_LAST_IDX 4'h9
`define LSH_ZERO_IDX 4'h0
`define LSH_ALL_PASS_N 9'h1ff
`endif

// ===== core/lsh_pkg.sv
// Types for the list sweep handler output block.
// Assumes lsh_defs.svh is on the include path.
`include "lsh_defs.svh"
package lsh_pkg;
  typedef enum logic [1:0] {lsh_idle, lsh_run, lsh_done} lsh_state_t;
  typedef logic [`LSH_NPOINTS-1:0] lsh_flags_t;
endpackage

// ===== core/lsh_judge_if.sv
// Interface carrying per-point judgements from the collector to the top.
// Assumes one clock domain.
`timescale 1ns/1ps
interface lsh_judge_if;
  import lsh_pkg::*;
  lsh_flags_t flags;
  logic any_fail;
  modport src (output flags, output any_fail);
  modport dst (input flags, input any_fail);
endinterface

// ===== core/lsh_collect.sv
// Collects per-point limit judgements of one sweep.
// Assumes point results arrive as one-cycle pulses on ref_clk.
`timescale 1ns/1ps
`include "lsh_defs.svh"
module lsh_collect
  import lsh_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic cmp_valid,
  input wire logic [`LSH_IDX_W-1:0] cmp_index,
  input wire logic cmp_fail,
  lsh_judge_if.src judge
);
  lsh_flags_t flags;

  // ****************************************
  // Per-point fail flags.
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < `LSH_NPOINTS; g++) begin : g_pt
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          flags[g] <= 1'b0;
        end else if (clear) begin
          flags[g] <= 1'b0;
        end else if (cmp_valid && cmp_index == `LSH_IDX_W'(g)) begin
          flags[g] <= cmp_fail;
        end
      end
    end
  endgenerate

  assign judge.flags = flags;
  assign judge.any_fail = |flags;
endmodule

// ===== dv/lsh_handler.sv
// Handler model that latches the judgements when end of measurement falls.
// Assumes the outputs of lsh_top on ref_clk.
`timescale 1ns/1ps
module lsh_handler (
  input wire logic ref_clk,
  input wire logic meas_end_n,
  input wire logic [10:0] judge_n,
  output logic [10:0] seen_n
);
  logic end_q;
  always_ff @(posedge ref_clk) begin
    end_q <= meas_end_n;
    if (end_q && !meas_end_n) begin
      seen_n <= judge_n;
    end
  end
endmodule

// ===== dv/list_sweep_handler_outputs_tb.sv
// Testbench for lsh_top with a handler model on its outputs.
// Assumes the design files of the core folder.
`timescale 1ns/1ps
`include "lsh_defs.svh"
module list_sweep_handler_outputs_tb;
  import lsh_pkg::*;
  // ****************
  // Stimulus and checks.
  // ****************
  logic ref_clk, rst, sequential_sweep, sweep_start, analog_done, cmp_valid, cmp_fail;
  logic [3:0] analog_index, cmp_index;
  logic [8:0] point_fail_n;
  logic point10_fail_n, any_fail_n, index_n, meas_end_n;
  logic [10:0] seen_n;
  logic [9:0] last;
  int num_errors, n_compared, cycles;
  lsh_top dut_u (.ref_clk(ref_clk), .rst(rst), .sequential_sweep(sequential_sweep),
    .sweep_start(sweep_start), .analog_done(analog_done), .analog_index(analog_index),
    .cmp_valid(cmp_valid), .cmp_index(cmp_index), .cmp_fail(cmp_fail),
    .point_fail_n(point_fail_n), .point10_fail_n(point10_fail_n),
    .any_fail_n(any_fail_n), .index_n(index_n), .meas_end_n(meas_end_n));
  lsh_handler hnd_u (.ref_clk(ref_clk), .meas_end_n(meas_end_n),
    .judge_n({point10_fail_n, point_fail_n, any_fail_n}), .seen_n(seen_n));
  task chk(input string nm, input logic [10:0] seen, input logic [10:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task test_done;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task sweep(input logic mode, input logic [9:0] f);
    sequential_sweep = mode;
    sweep_start = 1'b1;
    cyc(1);
    sweep_start = 1'b0;
    cyc(2);
    chk("strobes", {9'h0, index_n, meas_end_n}, 11'h3);
    chk("held", {1'b0, point10_fail_n, point_fail_n}, {1'b0, ~last});
    for (int i = 0; i < 10; i++) begin
      analog_done = 1'b1;
      analog_index = i[3:0];
      cyc(1);
      analog_done = 1'b0;
      cmp_valid = 1'b1;
      cmp_index = i[3:0];
      cmp_fail = f[i];
      cyc(1);
      cmp_valid = 1'b0;
      cyc(2);
      if (mode && i < 9) chk("end_seq", {10'h0, meas_end_n}, 11'h1);
      if (!mode) chk("end_step", {10'h0, meas_end_n}, 11'h0);
    end
    cyc(1);
    chk("ends", {9'h0, index_n, meas_end_n}, 11'h0);
    chk("points", {1'b0, point10_fail_n, point_fail_n}, {1'b0, ~f});
    chk("any", {10'h0, any_fail_n}, {10'h0, f == 10'h0});
    chk("handler", seen_n, {~f, f == 10'h0});
    last = f;
  endtask
  task t_seq;
    sweep(1'b1, 10'h201);
  endtask
  task t_step;
    sweep(1'b0, 10'h010);
  endtask
  task t_pass;
    sweep(1'b1, 10'h000);
  endtask
  task t_stray;
    cmp_valid = 1'b1;
    cmp_index = 4'h3;
    cmp_fail = 1'b1;
    cyc(1);
    cmp_valid = 1'b0;
    cyc(2);
    chk("stray_end", {10'h0, meas_end_n}, 11'h0);
    chk("stray_pts", {1'b0, point10_fail_n, point_fail_n}, {1'b0, ~last});
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      test_done();
    end
  end
  initial begin
    {rst, sequential_sweep, sweep_start, analog_done, cmp_valid, cmp_fail} = 6'h21;
    {analog_index, cmp_index} = 8'h00;
    last = 10'h000;
    cyc(3);
    rst = 1'b0;
    cyc(1);
    t_seq();
    t_step();
    t_pass();
    t_stray();
    test_done();
  end
endmodule
